//--- common/tmsl_pkg.sv
// Register map, field positions, reset values and state type of the block
package tmsl_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PRIMARY_STATUS   = 8'h02;
    localparam logic [7:0] ADDR_REMOTE_SHUTDOWN  = 8'h07;
    localparam logic [7:0] ADDR_REMOTE_CRITICAL  = 8'h19;
    localparam logic [7:0] ADDR_LOCAL_SHARED     = 8'h20;
    localparam logic [7:0] ADDR_COMMON_HYST      = 8'h21;
    localparam logic [7:0] ADDR_SECONDARY_STATUS = 8'h33;
    localparam logic [7:0] ADDR_MAKER_ID         = 8'hfe;
    localparam logic [7:0] ADDR_DIE_REVISION     = 8'hff;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned PS_BUSY_BIT      = 7;
    localparam int unsigned PS_RSHUT_BIT     = 4;
    localparam int unsigned PS_FAULT_BIT     = 2;
    localparam int unsigned PS_RCRIT_BIT     = 1;
    localparam int unsigned PS_LOCAL_BIT     = 0;
    localparam int unsigned SS_NOT_READY_BIT = 7;
    localparam int unsigned SS_DETECT_BIT    = 6;
    localparam int unsigned HYST_W           = 5;
    localparam int unsigned TEMP_W           = 16;

    // ------------------------------------------------------------------
    // Reset values and fixed codes
    // ------------------------------------------------------------------
    localparam logic [7:0]        RST_REMOTE_SHUTDOWN = 8'h55;
    localparam logic [7:0]        RST_REMOTE_CRITICAL = 8'h6e;
    localparam logic [7:0]        RST_LOCAL_SHARED    = 8'h55;
    localparam logic [HYST_W-1:0] RST_COMMON_HYST     = 5'h0a;
    localparam logic [7:0]        REG_ZERO            = 8'h00;
    // Identification codes: arbitrary neutral values
    localparam logic [7:0]        MAKER_CODE_DFLT     = 8'h5a;
    localparam logic [7:0]        REVISION_CODE_DFLT  = 8'h10;

    // Remote readout while the junction is faulted
    localparam logic [TEMP_W-1:0] FAULT_UNSIGNED_VAL  = 16'h0000;
    localparam logic [TEMP_W-1:0] FAULT_SIGNED_VAL    = 16'h8000;

    // ------------------------------------------------------------------
    // Power-up timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ      = 20_000_000;
    localparam int unsigned POWERUP_TIME_MS  = 30;
    localparam int unsigned MS_PER_S         = 1000;
    localparam int unsigned PWR_CNT_W        = 20;
    localparam int unsigned POWERUP_CYC_INT  =
        POWERUP_TIME_MS * (CLK_FREQ_HZ / MS_PER_S);
    localparam logic [PWR_CNT_W-1:0] POWERUP_CYCLES_DFLT =
        PWR_CNT_W'(POWERUP_CYC_INT);
    localparam logic [PWR_CNT_W-1:0] PWR_CNT_ONE = 20'h00001;

    // ------------------------------------------------------------------
    // State of the register bank
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]           rshut_lim;
        logic [7:0]           rcrit_lim;
        logic [7:0]           local_lim;
        logic [HYST_W-1:0]    hyst;
        logic [7:0]           rdata;
        logic [PWR_CNT_W-1:0] pwr_cnt;
        logic                 not_ready;
        logic [TEMP_W-1:0]    rem_uns;
        logic [TEMP_W-1:0]    rem_sgn;
        logic                 shutdown_n;
        logic                 critical_n;
    } tmsl_state_t;

    localparam tmsl_state_t STATE_RST = '{
        rshut_lim:  RST_REMOTE_SHUTDOWN,
        rcrit_lim:  RST_REMOTE_CRITICAL,
        local_lim:  RST_LOCAL_SHARED,
        hyst:       RST_COMMON_HYST,
        rdata:      REG_ZERO,
        pwr_cnt:    '0,
        not_ready:  1'b1,
        rem_uns:    FAULT_UNSIGNED_VAL,
        rem_sgn:    FAULT_UNSIGNED_VAL,
        shutdown_n: 1'b1,
        critical_n: 1'b1
    };

    typedef struct packed {
        logic flag;
    } tmsl_cmp_state_t;

endpackage

//--- hw/tmsl_limit_cmp.sv
// Limit comparator with hysteresis, one flag per channel and limit
`timescale 1ns/10ps

module tmsl_limit_cmp
(
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        update_in,
    input  wire logic [7:0]                  temp_in,
    input  wire logic [7:0]                  limit_in,
    input  wire logic [tmsl_pkg::HYST_W-1:0] hyst_in,
    output logic                             flag_out
);
    import tmsl_pkg::*;

    tmsl_cmp_state_t state_reg;
    tmsl_cmp_state_t state_next;
    logic [7:0]      hyst_ext;
    logic [7:0]      low_mark;

    // Saturate at zero so a large hysteresis never wraps the release point
    assign hyst_ext = {3'h0, hyst_in};
    assign low_mark = (limit_in > hyst_ext) ? (limit_in - hyst_ext) : 8'h00;

    always_comb
    begin
        state_next = state_reg;
        if (update_in)
        begin
            if (temp_in > limit_in)
                state_next.flag = 1'b1;
            else if (temp_in < low_mark)
                state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign flag_out = state_reg.flag;

endmodule

//--- hw/tmsl_regs.sv
// Status, limit, hysteresis and identification registers of the monitor
`timescale 1ns/10ps

// Notes on behaviour
// - status one bit 7 shows conversion busy
// - status one bit 4 remote shutdown flag
// - status one bit 1 remote critical flag
// - status one bit 0 combined local flag
// - status one bit 2 remote junction fault
// - faulted remote readout gives zero or minimum
// - status two bit 7 set during power-up
// - status two bit 6 discrete sensor detect
// - reserved status bits read as zero
// - remote shutdown limit, resets to 85
// - shared local limit, resets to 85
// - remote critical limit, resets to 110
// - five-bit common hysteresis, resets to 10
// - fixed maker code, writes ignored
// - fixed die revision code
module tmsl_regs
#(
    parameter logic [tmsl_pkg::PWR_CNT_W-1:0] POWERUP_CYCLES =
        tmsl_pkg::POWERUP_CYCLES_DFLT,
    parameter logic [7:0] MAKER_CODE    = tmsl_pkg::MAKER_CODE_DFLT,
    parameter logic [7:0] REVISION_CODE = tmsl_pkg::REVISION_CODE_DFLT
)
(
    input  wire logic                        SYS_CLK_IN,
    input  wire logic                        RSTN_IN,
    // Register access from the serial bus engine
    input  wire logic [7:0]                  REG_ADDR_IN,
    input  wire logic                        REG_WR_IN,
    input  wire logic [7:0]                  REG_WDATA_IN,
    input  wire logic                        REG_RD_IN,
    output logic [7:0]                       REG_RDATA_OUT,
    // Measurement side
    input  wire logic                        CONV_BUSY_IN,
    input  wire logic                        TEMP_UPDATE_IN,
    input  wire logic [7:0]                  REMOTE_TEMP_IN,
    input  wire logic [7:0]                  LOCAL_TEMP_IN,
    input  wire logic                        DIODE_FAULT_IN,
    input  wire logic                        SENSOR_DETECT_IN,
    input  wire logic                        BETA_MODE_IN,
    input  wire logic [tmsl_pkg::TEMP_W-1:0] REMOTE_UNSIGNED_IN,
    input  wire logic [tmsl_pkg::TEMP_W-1:0] REMOTE_SIGNED_IN,
    output logic [tmsl_pkg::TEMP_W-1:0]      REMOTE_UNSIGNED_OUT,
    output logic [tmsl_pkg::TEMP_W-1:0]      REMOTE_SIGNED_OUT,
    // Alarm pins and flags
    output logic                             SHUTDOWN_N_OUT,
    output logic                             CRITICAL_N_OUT,
    output logic                             REMOTE_SHUTDOWN_FLAG_OUT,
    output logic                             REMOTE_CRITICAL_FLAG_OUT,
    output logic                             LOCAL_LIMIT_FLAG_OUT,
    output logic                             NOT_READY_OUT
);
    import tmsl_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    tmsl_state_t state_reg;
    tmsl_state_t state_next;

    logic        remote_shutdown_flag;
    logic        remote_critical_flag;
    logic        local_limit_flag;
    logic [7:0]  remote_cmp_temp;
    logic [7:0]  primary_status;
    logic [7:0]  secondary_status;
    logic        discrete_sensor_detect;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Places one bit into an otherwise zero byte; every unused position
    // of a status byte therefore reads zero
    function automatic logic [7:0] put_bit
    (
        input logic        value,
        input int unsigned pos
    );
        logic [7:0] b;
        b      = 8'h00;
        b[pos] = value;
        return b;
    endfunction

    // Replaces a remote readout with its fault value
    function automatic logic [TEMP_W-1:0] fault_fill
    (
        input logic              fault,
        input logic [TEMP_W-1:0] value,
        input logic [TEMP_W-1:0] fill
    );
        return fault ? fill : value;
    endfunction

    // ------------------------------------------------------------------
    // Limit comparators
    // ------------------------------------------------------------------
    // A faulted junction compares as zero degrees, so remote flags fall
    // away rather than freeze at the last good reading
    assign remote_cmp_temp = DIODE_FAULT_IN ? 8'h00 : REMOTE_TEMP_IN;

    tmsl_limit_cmp u_remote_shutdown
    (
        .clk_in    (SYS_CLK_IN),
        .rstn_in   (RSTN_IN),
        .update_in (TEMP_UPDATE_IN),
        .temp_in   (remote_cmp_temp),
        .limit_in  (state_reg.rshut_lim),
        .hyst_in   (state_reg.hyst),
        .flag_out  (remote_shutdown_flag)
    );

    tmsl_limit_cmp u_remote_critical
    (
        .clk_in    (SYS_CLK_IN),
        .rstn_in   (RSTN_IN),
        .update_in (TEMP_UPDATE_IN),
        .temp_in   (remote_cmp_temp),
        .limit_in  (state_reg.rcrit_lim),
        .hyst_in   (state_reg.hyst),
        .flag_out  (remote_critical_flag)
    );

    // One comparator serves both local alarms since they share a limit
    tmsl_limit_cmp u_local_shared
    (
        .clk_in    (SYS_CLK_IN),
        .rstn_in   (RSTN_IN),
        .update_in (TEMP_UPDATE_IN),
        .temp_in   (LOCAL_TEMP_IN),
        .limit_in  (state_reg.local_lim),
        .hyst_in   (state_reg.hyst),
        .flag_out  (local_limit_flag)
    );

    // ------------------------------------------------------------------
    // Status bytes
    // ------------------------------------------------------------------
    // Detect follows the sensor detect input with beta compensation on, zero with it off
    assign discrete_sensor_detect = SENSOR_DETECT_IN & BETA_MODE_IN;

    assign primary_status =
        put_bit(CONV_BUSY_IN,         PS_BUSY_BIT)    |
        put_bit(remote_shutdown_flag, PS_RSHUT_BIT)   |
        put_bit(DIODE_FAULT_IN,       PS_FAULT_BIT)   |
        put_bit(remote_critical_flag, PS_RCRIT_BIT)   |
        put_bit(local_limit_flag,     PS_LOCAL_BIT);

    assign secondary_status =
        put_bit(state_reg.not_ready,    SS_NOT_READY_BIT) |
        put_bit(discrete_sensor_detect, SS_DETECT_BIT);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;

        // Power-up sequence timer
        if (state_reg.not_ready)
        begin
            if (state_reg.pwr_cnt >= POWERUP_CYCLES - PWR_CNT_ONE)
                state_next.not_ready = 1'b0;
            else
                state_next.pwr_cnt = state_reg.pwr_cnt + PWR_CNT_ONE;
        end

        // Register writes; read-only and unmapped addresses fall through
        if (REG_WR_IN)
        begin
            unique case (REG_ADDR_IN)
                ADDR_REMOTE_SHUTDOWN:
                    state_next.rshut_lim = REG_WDATA_IN;
                ADDR_REMOTE_CRITICAL:
                    state_next.rcrit_lim = REG_WDATA_IN;
                ADDR_LOCAL_SHARED:
                    state_next.local_lim = REG_WDATA_IN;
                ADDR_COMMON_HYST:
                    state_next.hyst = REG_WDATA_IN[HYST_W-1:0];
                default:
                    state_next.rdata = state_reg.rdata;
            endcase
        end

        // Register reads
        if (REG_RD_IN)
        begin
            unique case (REG_ADDR_IN)
                ADDR_PRIMARY_STATUS:
                    state_next.rdata = primary_status;
                ADDR_SECONDARY_STATUS:
                    state_next.rdata = secondary_status;
                ADDR_REMOTE_SHUTDOWN:
                    state_next.rdata = state_reg.rshut_lim;
                ADDR_REMOTE_CRITICAL:
                    state_next.rdata = state_reg.rcrit_lim;
                ADDR_LOCAL_SHARED:
                    state_next.rdata = state_reg.local_lim;
                ADDR_COMMON_HYST:
                    state_next.rdata = {3'h0, state_reg.hyst};
                ADDR_MAKER_ID:
                    state_next.rdata = MAKER_CODE;
                ADDR_DIE_REVISION:
                    state_next.rdata = REVISION_CODE;
                default:
                    state_next.rdata = REG_ZERO;
            endcase
        end

        // Remote readouts are overridden while the junction is faulted
        state_next.rem_uns = fault_fill(DIODE_FAULT_IN,
                                        REMOTE_UNSIGNED_IN,
                                        FAULT_UNSIGNED_VAL);
        state_next.rem_sgn = fault_fill(DIODE_FAULT_IN,
                                        REMOTE_SIGNED_IN,
                                        FAULT_SIGNED_VAL);

        // Active-low alarm pins; each ORs its remote flag with the local flag
        state_next.shutdown_n = ~(remote_shutdown_flag | local_limit_flag);
        state_next.critical_n = ~(remote_critical_flag | local_limit_flag);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            state_reg <= STATE_RST;
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign REG_RDATA_OUT            = state_reg.rdata;
    assign REMOTE_UNSIGNED_OUT      = state_reg.rem_uns;
    assign REMOTE_SIGNED_OUT        = state_reg.rem_sgn;
    assign SHUTDOWN_N_OUT           = state_reg.shutdown_n;
    assign CRITICAL_N_OUT           = state_reg.critical_n;
    assign REMOTE_SHUTDOWN_FLAG_OUT = remote_shutdown_flag;
    assign REMOTE_CRITICAL_FLAG_OUT = remote_critical_flag;
    assign LOCAL_LIMIT_FLAG_OUT     = local_limit_flag;
    assign NOT_READY_OUT            = state_reg.not_ready;

endmodule

//--- verification/tmsl_regs_sva.sv
// Concurrent checks on the ports of the register bank
`timescale 1ns/10ps

module tmsl_regs_sva
#(
    parameter logic [tmsl_pkg::PWR_CNT_W-1:0] POWERUP_CYCLES =
        tmsl_pkg::POWERUP_CYCLES_DFLT,
    parameter logic [7:0] MAKER_CODE    = tmsl_pkg::MAKER_CODE_DFLT,
    parameter logic [7:0] REVISION_CODE = tmsl_pkg::REVISION_CODE_DFLT
)
(
    input  wire logic                        SYS_CLK_IN,
    input  wire logic                        RSTN_IN,
    input  wire logic [7:0]                  REG_ADDR_IN,
    input  wire logic                        REG_RD_IN,
    input  wire logic [7:0]                  REG_RDATA_OUT,
    input  wire logic                        CONV_BUSY_IN,
    input  wire logic                        TEMP_UPDATE_IN,
    input  wire logic                        DIODE_FAULT_IN,
    input  wire logic                        SENSOR_DETECT_IN,
    input  wire logic                        BETA_MODE_IN,
    input  wire logic [tmsl_pkg::TEMP_W-1:0] REMOTE_UNSIGNED_IN,
    input  wire logic [tmsl_pkg::TEMP_W-1:0] REMOTE_UNSIGNED_OUT,
    input  wire logic [tmsl_pkg::TEMP_W-1:0] REMOTE_SIGNED_OUT,
    input  wire logic                        SHUTDOWN_N_OUT,
    input  wire logic                        CRITICAL_N_OUT,
    input  wire logic                        REMOTE_SHUTDOWN_FLAG_OUT,
    input  wire logic                        REMOTE_CRITICAL_FLAG_OUT,
    input  wire logic                        LOCAL_LIMIT_FLAG_OUT,
    input  wire logic                        NOT_READY_OUT
);
    import tmsl_pkg::*;

    // Edges seen since reset, saturating at the power-up length
    logic [PWR_CNT_W-1:0] up_cnt_reg;

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            up_cnt_reg <= '0;
        else if (up_cnt_reg < POWERUP_CYCLES)
            up_cnt_reg <= up_cnt_reg + PWR_CNT_ONE;
    end

    a_busy_bit: assert property (
        REG_RD_IN && REG_ADDR_IN == ADDR_PRIMARY_STATUS
        |=> REG_RDATA_OUT[7] == $past(CONV_BUSY_IN))
        else $error("busy bit wrong");
    a_flag_bits: assert property (
        REG_RD_IN && REG_ADDR_IN == ADDR_PRIMARY_STATUS
        |=> {REG_RDATA_OUT[4], REG_RDATA_OUT[1], REG_RDATA_OUT[0]} ==
            {$past(REMOTE_SHUTDOWN_FLAG_OUT), $past(REMOTE_CRITICAL_FLAG_OUT),
             $past(LOCAL_LIMIT_FLAG_OUT)})
        else $error("status flag bits wrong");
    a_fault_bit: assert property (
        REG_RD_IN && REG_ADDR_IN == ADDR_PRIMARY_STATUS
        |=> REG_RDATA_OUT[2] == $past(DIODE_FAULT_IN))
        else $error("fault bit wrong");
    a_reserved_zero: assert property (
        REG_RD_IN && REG_ADDR_IN == ADDR_PRIMARY_STATUS
        |=> REG_RDATA_OUT[6:5] == 2'h0 && REG_RDATA_OUT[3] == 1'b0)
        else $error("reserved status bits set");
    a_status_two: assert property (
        REG_RD_IN && REG_ADDR_IN == ADDR_SECONDARY_STATUS
        |=> REG_RDATA_OUT == {$past(NOT_READY_OUT),
            $past(SENSOR_DETECT_IN) & $past(BETA_MODE_IN), 6'h00})
        else $error("second status wrong");
    a_ident_codes: assert property (
        REG_RD_IN && REG_ADDR_IN >= ADDR_MAKER_ID
        |=> REG_RDATA_OUT ==
            ($past(REG_ADDR_IN[0]) ? REVISION_CODE : MAKER_CODE))
        else $error("identification code wrong");
    a_hyst_upper: assert property (
        REG_RD_IN && REG_ADDR_IN == ADDR_COMMON_HYST
        |=> REG_RDATA_OUT[7:5] == 3'h0)
        else $error("hysteresis upper bits set");
    a_fault_readout: assert property (
        DIODE_FAULT_IN |=> REMOTE_UNSIGNED_OUT == FAULT_UNSIGNED_VAL
            && REMOTE_SIGNED_OUT == FAULT_SIGNED_VAL)
        else $error("faulted readout wrong");
    a_clean_readout: assert property (
        !DIODE_FAULT_IN |=> REMOTE_UNSIGNED_OUT == $past(REMOTE_UNSIGNED_IN))
        else $error("readout not passed through");
    a_flags_hold: assert property (
        !TEMP_UPDATE_IN |=> $stable(REMOTE_SHUTDOWN_FLAG_OUT)
            && $stable(REMOTE_CRITICAL_FLAG_OUT) && $stable(LOCAL_LIMIT_FLAG_OUT))
        else $error("flag moved without update");
    a_shutdown_pin: assert property (
        1'b1 |=> SHUTDOWN_N_OUT ==
            !($past(REMOTE_SHUTDOWN_FLAG_OUT) | $past(LOCAL_LIMIT_FLAG_OUT)))
        else $error("shutdown pin wrong");
    a_critical_pin: assert property (
        1'b1 |=> CRITICAL_N_OUT ==
            !($past(REMOTE_CRITICAL_FLAG_OUT) | $past(LOCAL_LIMIT_FLAG_OUT)))
        else $error("critical pin wrong");
    a_ready_window: assert property (
        NOT_READY_OUT == (up_cnt_reg < POWERUP_CYCLES))
        else $error("not ready timing wrong");
endmodule

//--- verification/tmsl_host_model.sv
// Bus host model driving the parallel register port
`timescale 1ns/10ps

module tmsl_host_model
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic [7:0]      addr_out,
    output logic            wr_out,
    output logic [7:0]      wdata_out,
    output logic            rd_out
);
    initial
    begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        rd_out = 1'b0;
    end

    // Released lines show the inverse so a stale value never matches
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        addr_out = ~a;
        d = rdata_in;
    endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench of the register bank
`timescale 1ns/10ps

module tb_top;
    import tmsl_pkg::*;

    localparam logic [PWR_CNT_W-1:0] PWR_CYC = 20'h00014;
    localparam logic [7:0] MAKER = 8'h3c;   // Arbitrary value
    localparam logic [7:0] REV   = 8'h21;   // Arbitrary value

    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic [7:0]        addr, wdata, rdata, rtemp = 8'h00, ltemp = 8'h00;
    logic              wr, rd, busy = 1'b0, upd = 1'b0, fault = 1'b0;
    logic              sens = 1'b0, beta = 1'b0, nrdy, snd, crn;
    logic [TEMP_W-1:0] uns_in = 16'h0000, sgn_in = 16'h0000, uns, sgn;
    logic              rsf, rcf, llf;
    logic [7:0]        ro_a [5] = '{8'h02, 8'h33, 8'hfe, 8'hff, 8'h40};
    logic [7:0]        rw_a [4] = '{8'h07, 8'h19, 8'h20, 8'h21};
    logic [7:0]        pat [3] = '{8'h00, 8'hff, 8'ha5};
    int                fails = 0;
    int                n_compared = 0;

    always #25 clk = ~clk;

    tmsl_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wr_out(wr), .wdata_out(wdata), .rd_out(rd));

    tmsl_regs #(.POWERUP_CYCLES(PWR_CYC), .MAKER_CODE(MAKER),
        .REVISION_CODE(REV)) dut (
        .SYS_CLK_IN(clk), .RSTN_IN(rstn), .REG_ADDR_IN(addr),
        .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdata), .CONV_BUSY_IN(busy), .TEMP_UPDATE_IN(upd),
        .REMOTE_TEMP_IN(rtemp), .LOCAL_TEMP_IN(ltemp),
        .DIODE_FAULT_IN(fault), .SENSOR_DETECT_IN(sens),
        .BETA_MODE_IN(beta), .REMOTE_UNSIGNED_IN(uns_in),
        .REMOTE_SIGNED_IN(sgn_in), .REMOTE_UNSIGNED_OUT(uns),
        .REMOTE_SIGNED_OUT(sgn), .SHUTDOWN_N_OUT(snd), .CRITICAL_N_OUT(crn),
        .REMOTE_SHUTDOWN_FLAG_OUT(rsf), .REMOTE_CRITICAL_FLAG_OUT(rcf),
        .LOCAL_LIMIT_FLAG_OUT(llf), .NOT_READY_OUT(nrdy));

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        chk16({8'h00, d}, {8'h00, exp});
    endtask

    task automatic update(input logic [7:0] r, input logic [7:0] l);
        @(posedge clk);
        #1;
        rtemp = r;
        ltemp = l;
        upd = 1'b1;
        @(posedge clk);
        #1;
        upd = 1'b0;
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        rd_chk(8'h07, 8'h55);
        rd_chk(8'h19, 8'h6e);
        rd_chk(8'h20, 8'h55);
        rd_chk(8'h21, 8'h0a);
        rd_chk(8'h33, 8'h80);
        $display("test reset values done");
        foreach (ro_a[i])
            host.write_reg(ro_a[i], 8'hff);
        rd_chk(8'hfe, MAKER);
        rd_chk(8'hff, REV);
        rd_chk(8'h40, 8'h00);
        rd_chk(8'h02, 8'h00);
        $display("test read-only writes done");
        foreach (pat[p])
            foreach (rw_a[i])
            begin
                host.write_reg(rw_a[i], pat[p]);
                rd_chk(rw_a[i], (i == 3) ? (pat[p] & 8'h1f) : pat[p]);
            end
        host.write_reg(8'h07, 8'h55);
        host.write_reg(8'h19, 8'h64);
        host.write_reg(8'h20, 8'h28);
        host.write_reg(8'h21, 8'h0a);
        $display("test limit access done");
        for (int i = 0; i < 40 && nrdy !== 1'b0; i++)
            @(posedge clk);
        if (nrdy !== 1'b0)
        begin
            fails++;
            tally_and_finish();
        end
        for (int i = 0; i < 4; i++)
        begin
            {sens, beta} = i[1:0];
            rd_chk(8'h33, (i == 3) ? 8'h40 : 8'h00);
        end
        $display("test second status done");
        busy = 1'b1;
        fault = 1'b1;
        uns_in = 16'h1234;
        sgn_in = 16'hfedc;
        rd_chk(8'h02, 8'h84);
        chk16(uns, FAULT_UNSIGNED_VAL);
        chk16(sgn, FAULT_SIGNED_VAL);
        busy = 1'b0;
        fault = 1'b0;
        @(posedge clk);
        #1;
        chk16(uns, 16'h1234);
        chk16(sgn, 16'hfedc);
        $display("test busy and fault done");
        // Limits 85, 100, 40 with hysteresis 10
        update(8'h56, 8'h29);
        rd_chk(8'h02, 8'h11);
        chk16({14'h0, snd, crn}, 16'h0000);
        update(8'h65, 8'h29);
        rd_chk(8'h02, 8'h13);
        update(8'h4b, 8'h1e);
        rd_chk(8'h02, 8'h11);
        update(8'h4a, 8'h1d);
        rd_chk(8'h02, 8'h00);
        chk16({14'h0, snd, crn}, 16'h0003);
        $display("test limit flags done");
        // Reset in mid-run with flags set must restore the critical and local limit defaults and clear the flags
        update(8'h56, 8'h29);
        @(posedge clk);
        #1;
        rstn = 1'b0;
        @(posedge clk);
        #1;
        rstn = 1'b1;
        rd_chk(8'h19, 8'h6e);
        rd_chk(8'h20, 8'h55);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h33, 8'hc0);
        update(8'h65, 8'h00);
        rd_chk(8'h02, 8'h10);
        chk16({14'h0, snd, crn}, 16'h0001);
        $display("test mid-run reset done");
        tally_and_finish();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule

bind tmsl_regs tmsl_regs_sva #(.POWERUP_CYCLES(POWERUP_CYCLES),
    .MAKER_CODE(MAKER_CODE), .REVISION_CODE(REVISION_CODE)) u_sva (
    .SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .CONV_BUSY_IN(CONV_BUSY_IN), .TEMP_UPDATE_IN(TEMP_UPDATE_IN),
    .DIODE_FAULT_IN(DIODE_FAULT_IN), .SENSOR_DETECT_IN(SENSOR_DETECT_IN),
    .BETA_MODE_IN(BETA_MODE_IN), .REMOTE_UNSIGNED_IN(REMOTE_UNSIGNED_IN),
    .REMOTE_UNSIGNED_OUT(REMOTE_UNSIGNED_OUT),
    .REMOTE_SIGNED_OUT(REMOTE_SIGNED_OUT), .SHUTDOWN_N_OUT(SHUTDOWN_N_OUT),
    .CRITICAL_N_OUT(CRITICAL_N_OUT),
    .REMOTE_SHUTDOWN_FLAG_OUT(REMOTE_SHUTDOWN_FLAG_OUT),
    .REMOTE_CRITICAL_FLAG_OUT(REMOTE_CRITICAL_FLAG_OUT),
    .LOCAL_LIMIT_FLAG_OUT(LOCAL_LIMIT_FLAG_OUT), .NOT_READY_OUT(NOT_READY_OUT));
